// >>> hdl/etsm_pin_mux.sv
// Contract
// - Low level on test reset pad resets the JTAG TAP controller.
// - Test-port pull-up disabled while system pull-up disable test bit is set.
// - Pad 0 defaults to phase A; alternatives timer ch0, port C bit4.
// - Pad 1 defaults to phase B; alternatives timer ch1, port C bit5.
// - Pad 2 defaults to index; alternatives timer ch2, port C bit6.
// - Pad 3 defaults to home; alternatives timer ch3, port C bit7.
// - SPI master drives serial clock pad; slave uses it as clock input.
// - Clock pad defaults to SPI clock, alternative port E bit4, pull-up bit4.
// - In GPIO function each pad is individually input or output.
`timescale 1ns/1ps
`default_nettype none

module etsm_pin_mux
	import etsm_pkg::*;
(
	input  wire logic       sys_clk,                   // System clock, 125 MHz
	input  wire logic       sys_rst,                   // Device reset, sync, active high
	// Selection and pull-up configuration
	input  wire logic       sel_wr,                    // Load new function selections
	input  wire logic [7:0] enc_sel_wdata,             // Two bits per encoder pad
	input  wire logic       sclk_gpio_wdata,           // 1 = clock pad to port E bit4
	input  wire logic       pullup_wr,                 // Load pull-up registers
	input  wire logic [7:0] port_c_pullup_enable_reg,  // Port C pull-up enables
	input  wire logic [7:0] port_e_pullup_enable_reg,  // Port E pull-up enables
	input  wire logic [7:0] system_pullup_disable_reg, // System pull-up disables
	output logic      [7:0] enc_sel_rdata,             // Current encoder selections
	output logic            sclk_gpio_rdata,           // Current clock pad selection
	// Encoder pads
	input  wire logic [3:0] enc_pad_i,                 // Pad levels
	output logic      [3:0] enc_pad_o,                 // Pad drive values
	output logic      [3:0] enc_pad_oe,                // Pad drive enables
	output logic      [3:0] enc_pad_pu_en,             // Pull-up enables
	// Decoder inputs
	output logic            enc0_phase_a,              // Phase A to decoder
	output logic            enc0_phase_b,              // Phase B to decoder
	output logic            enc0_index_in,             // Index to decoder
	output logic            enc0_home_in,              // Home to decoder
	// Timer A channels
	input  wire logic [3:0] timer_a_o,                 // Timer channel outputs
	input  wire logic [3:0] timer_a_oe,                // Timer channel enables
	output logic      [3:0] timer_a_i,                 // Timer channel inputs
	// Port C bits 4..7
	input  wire logic [3:0] port_c_o,                  // GPIO output values
	input  wire logic [3:0] port_c_dir,                // GPIO direction, 1 = output
	output logic      [3:0] port_c_i,                  // GPIO input levels
	// SPI0 clock pad
	input  wire logic       spi0_master,               // SPI0 in master mode
	input  wire logic       spi0_clk_o,                // SPI0 clock out in master mode
	output logic            spi0_serial_clock,         // Clock seen by SPI0
	input  wire logic       sclk_pad_i,                // Pad level
	output logic            sclk_pad_o,                // Pad drive value
	output logic            sclk_pad_oe,               // Pad drive enable
	output logic            sclk_pad_pu_en,            // Pull-up enable
	input  wire logic       port_e_bit4_o,             // GPIO output value
	input  wire logic       port_e_bit4_dir,           // GPIO direction, 1 = output
	output logic            port_e_bit4,               // GPIO input level
	// Test reset pad
	input  wire logic       test_rst_pad_n,            // Test reset pad, active low
	output logic            tap_rst,                   // Reset to TAP controller
	output logic            test_rst_pu_en             // Pull-up enable on test reset pad
);

	////////////////////////////////////////////////////////////////////////////////
	// State

	// Selection and pull-up state, all in one register
	typedef struct packed {
		etsm_fn_t [3:0] enc_sel;
		logic           sclk_gpio;
		logic [7:0]     pc_pur;
		logic [7:0]     pe_pur;
		logic [7:0]     pudr;
	} etsm_state_t;

	etsm_state_t st_q;
	etsm_state_t st_d;

	always_comb begin
		st_d = st_q;
		// Both strobes may land in one cycle; they write disjoint fields
		if (sel_wr) begin
			for (int i = 0; i < ETSM_ENC_PADS; i++) begin
				// Code 3 is unused; it falls back to the decoder function
				unique case (enc_sel_wdata[2*i +: 2])
					2'h1:    st_d.enc_sel[i] = ETSM_FN_TIMER;
					2'h2:    st_d.enc_sel[i] = ETSM_FN_GPIO;
					default: st_d.enc_sel[i] = ETSM_FN_PERIPH;
				endcase
			end
			st_d.sclk_gpio = sclk_gpio_wdata;
		end
		if (pullup_wr) begin
			st_d.pc_pur = port_c_pullup_enable_reg;
			st_d.pe_pur = port_e_pullup_enable_reg;
			st_d.pudr   = system_pullup_disable_reg;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			for (int i = 0; i < ETSM_ENC_PADS; i++) begin
				st_q.enc_sel[i] <= ETSM_FN_RST;
			end
			st_q.sclk_gpio <= ETSM_SCLK_GPIO_RST;
			st_q.pc_pur    <= ETSM_PUR_RST;
			st_q.pe_pur    <= ETSM_PUR_RST;
			st_q.pudr      <= ETSM_PUDR_RST;
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Encoder pads

	// Inputs fan out to every sharer so a decoder keeps counting while a timer captures
	assign enc0_phase_a  = enc_pad_i[0];
	assign enc0_phase_b  = enc_pad_i[1];
	assign enc0_index_in = enc_pad_i[2];
	assign enc0_home_in  = enc_pad_i[3];
	assign timer_a_i     = enc_pad_i;
	assign port_c_i      = enc_pad_i;

	// Pad 0: phase A unless timer channel 0 or port C bit 4 is selected
	etsm_pad_sel u_enc0_sel (
		.sel     (st_q.enc_sel[0]),
		.per_o   (1'h0),             // Decoder inputs never drive
		.per_oe  (1'h0),
		.tmr_o   (timer_a_o[0]),
		.tmr_oe  (timer_a_oe[0]),
		.gpio_o  (port_c_o[0]),
		.gpio_oe (port_c_dir[0]),
		.pad_o   (enc_pad_o[0]),
		.pad_oe  (enc_pad_oe[0])
	);
	assign enc_pad_pu_en[0]   = st_q.pc_pur[ETSM_PC_BASE];
	assign enc_sel_rdata[1:0] = st_q.enc_sel[0];

	// Pad 1: phase B unless timer channel 1 or port C bit 5 is selected
	etsm_pad_sel u_enc1_sel (
		.sel     (st_q.enc_sel[1]),
		.per_o   (1'h0),
		.per_oe  (1'h0),
		.tmr_o   (timer_a_o[1]),
		.tmr_oe  (timer_a_oe[1]),
		.gpio_o  (port_c_o[1]),
		.gpio_oe (port_c_dir[1]),
		.pad_o   (enc_pad_o[1]),
		.pad_oe  (enc_pad_oe[1])
	);
	assign enc_pad_pu_en[1]   = st_q.pc_pur[ETSM_PC_BASE + 1];
	assign enc_sel_rdata[3:2] = st_q.enc_sel[1];

	// Pad 2: index unless timer channel 2 or port C bit 6 is selected
	etsm_pad_sel u_enc2_sel (
		.sel     (st_q.enc_sel[2]),
		.per_o   (1'h0),
		.per_oe  (1'h0),
		.tmr_o   (timer_a_o[2]),
		.tmr_oe  (timer_a_oe[2]),
		.gpio_o  (port_c_o[2]),
		.gpio_oe (port_c_dir[2]),
		.pad_o   (enc_pad_o[2]),
		.pad_oe  (enc_pad_oe[2])
	);
	assign enc_pad_pu_en[2]   = st_q.pc_pur[ETSM_PC_BASE + 2];
	assign enc_sel_rdata[5:4] = st_q.enc_sel[2];

	// Pad 3: home unless timer channel 3 or port C bit 7 is selected
	etsm_pad_sel u_enc3_sel (
		.sel     (st_q.enc_sel[3]),
		.per_o   (1'h0),
		.per_oe  (1'h0),
		.tmr_o   (timer_a_o[3]),
		.tmr_oe  (timer_a_oe[3]),
		.gpio_o  (port_c_o[3]),
		.gpio_oe (port_c_dir[3]),
		.pad_o   (enc_pad_o[3]),
		.pad_oe  (enc_pad_oe[3])
	);
	assign enc_pad_pu_en[3]   = st_q.pc_pur[ETSM_PC_BASE + 3];
	assign enc_sel_rdata[7:6] = st_q.enc_sel[3];

	////////////////////////////////////////////////////////////////////////////////
	// SPI0 clock pad

	etsm_fn_t sclk_fn;
	assign sclk_fn = st_q.sclk_gpio ? ETSM_FN_GPIO : ETSM_FN_PERIPH;

	// In slave mode SPI0 holds its enable low, so the pad stays a clock input
	etsm_pad_sel u_sclk_sel (
		.sel     (sclk_fn),
		.per_o   (spi0_clk_o),
		.per_oe  (spi0_master),
		.tmr_o   (1'h0),
		.tmr_oe  (1'h0),
		.gpio_o  (port_e_bit4_o),
		.gpio_oe (port_e_bit4_dir),
		.pad_o   (sclk_pad_o),
		.pad_oe  (sclk_pad_oe)
	);

	assign spi0_serial_clock = sclk_pad_i;
	assign port_e_bit4       = sclk_pad_i;
	assign sclk_pad_pu_en    = st_q.pe_pur[ETSM_PE_SCLK_BIT];
	assign sclk_gpio_rdata   = st_q.sclk_gpio;

	////////////////////////////////////////////////////////////////////////////////
	// Test reset pad

	// Kept combinational: the TAP must reset even with the system clock stopped
	assign tap_rst        = ~test_rst_pad_n;
	// Pull-up on by default so an unconnected test reset pad reads inactive
	assign test_rst_pu_en = ~st_q.pudr[ETSM_PUDR_TEST_BIT];

endmodule // etsm_pin_mux

`default_nettype wire

// >>> hdl/etsm_pkg.sv
`default_nettype none

package etsm_pkg;

	// Function selection per shared pad
	typedef enum logic [1:0] {
		ETSM_FN_PERIPH,
		ETSM_FN_TIMER,
		ETSM_FN_GPIO
	} etsm_fn_t;

	localparam int unsigned ETSM_ENC_PADS     = 4;
	// Pad position inside port C / port E for this group
	localparam int unsigned ETSM_PC_BASE      = 4;
	localparam int unsigned ETSM_PE_SCLK_BIT  = 4;
	// Bit position of the test-port flag in the system pull-up disable register
	localparam int unsigned ETSM_PUDR_TEST_BIT = 0;
	// Reset values of the selection and pull-up state
	localparam etsm_fn_t    ETSM_FN_RST       = ETSM_FN_PERIPH;
	localparam logic        ETSM_SCLK_GPIO_RST = 1'h0;
	localparam logic [7:0]  ETSM_PUR_RST      = 8'hff;
	localparam logic [7:0]  ETSM_PUDR_RST     = 8'h00;

endpackage : etsm_pkg

`default_nettype wire

// >>> hdl/etsm_pad_sel.sv
`timescale 1ns/1ps
`default_nettype none

// One shared pad: output value and enable come from the selected function only.
module etsm_pad_sel
	import etsm_pkg::*;
(
	input  wire etsm_fn_t sel,      // Selected function
	input  wire logic     per_o,    // Peripheral output value
	input  wire logic     per_oe,   // Peripheral output enable
	input  wire logic     tmr_o,    // Timer output value
	input  wire logic     tmr_oe,   // Timer output enable
	input  wire logic     gpio_o,   // GPIO output value
	input  wire logic     gpio_oe,  // GPIO direction, 1 = output
	output logic          pad_o,    // Pad output value
	output logic          pad_oe    // Pad output enable
);

	always_comb begin
		pad_o  = 1'h0;
		pad_oe = 1'h0;
		unique case (sel)
			ETSM_FN_PERIPH: begin
				pad_o  = per_o;
				pad_oe = per_oe;
			end
			ETSM_FN_TIMER: begin
				pad_o  = tmr_o;
				pad_oe = tmr_oe;
			end
			ETSM_FN_GPIO: begin
				pad_o  = gpio_o;
				pad_oe = gpio_oe;
			end
			default: begin
				pad_o  = 1'h0;
				pad_oe = 1'h0;
			end
		endcase
	end

endmodule // etsm_pad_sel

`default_nettype wire

// >>> verification/etsm_board.sv
`timescale 1ns/1ps
`default_nettype none
// Board side of the five pads: sensors and SPI partner
module etsm_board (
	input  wire logic       sys_clk, // Clock for float pattern
	input  wire logic [4:0] dev_oe,  // Device drive enables
	input  wire logic [4:0] dev_o,   // Device drive values
	input  wire logic [4:0] pu_en,   // Device pull-ups
	input  wire logic [4:0] ext_en,  // Board drives pad
	input  wire logic [4:0] ext_v,   // Board drive values
	output logic      [4:0] lvl      // Resolved levels
);
	logic tgl_q = 1'h0;
	always_ff @(posedge sys_clk) tgl_q <= ~tgl_q;
	// Unpulled floating pad wanders so no stale level can pass
	for (genvar i = 0; i < 5; i++) begin : g_pad
		assign lvl[i] = dev_oe[i] ? dev_o[i] : ext_en[i] ? ext_v[i] : pu_en[i] | tgl_q;
	end
endmodule // etsm_board
`default_nettype wire

// >>> verification/etsm_sva.sv
`timescale 1ns/1ps
`default_nettype none
module etsm_sva (
	input wire logic sys_clk, sys_rst, sel_wr, sclk_gpio_wdata, pullup_wr, // Control
	input wire logic [7:0] port_c_pullup_enable_reg, port_e_pullup_enable_reg, // Pull-ups
	input wire logic [7:0] system_pullup_disable_reg, enc_sel_rdata, // Config
	input wire logic [3:0] enc_pad_i, enc_pad_oe, enc_pad_pu_en, port_c_dir, // Pads
	input wire logic [3:0] timer_a_i, port_c_i, // Sharers
	input wire logic enc0_phase_a, enc0_phase_b, enc0_index_in, enc0_home_in, // Decoder
	input wire logic sclk_gpio_rdata, spi0_master, spi0_clk_o, spi0_serial_clock, // SPI
	input wire logic sclk_pad_i, sclk_pad_o, sclk_pad_oe, sclk_pad_pu_en, // Clock pad
	input wire logic port_e_bit4_dir, port_e_bit4, test_rst_pad_n, tap_rst, test_rst_pu_en // Misc
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	sequence pu_take; pullup_wr ##1 1'h1; endsequence
	rst_val_a: assert property ($past(sys_rst) |-> enc_sel_rdata == 8'h00 &&
		!sclk_gpio_rdata && enc_pad_pu_en == 4'hf && test_rst_pu_en) else $error("reset state");
	tap_rst_a: assert property (tap_rst == !test_rst_pad_n) else $error("tap reset");
	test_pu_a: assert property (pu_take |->
		test_rst_pu_en == !$past(system_pullup_disable_reg[0])) else $error("test pull-up");
	enc_pu_a: assert property (pu_take |->
		enc_pad_pu_en == $past(port_c_pullup_enable_reg[7:4])) else $error("enc pull-up");
	sclk_pu_a: assert property (pu_take |->
		sclk_pad_pu_en == $past(port_e_pullup_enable_reg[4])) else $error("clock pull-up");
	route_in_a: assert property ({enc0_home_in, enc0_index_in, enc0_phase_b,
		enc0_phase_a} == enc_pad_i && timer_a_i == enc_pad_i && port_c_i == enc_pad_i)
		else $error("pad input route");
	spi_drive_a: assert property (!sclk_gpio_rdata |-> sclk_pad_oe == spi0_master &&
		(sclk_pad_o == spi0_clk_o || !spi0_master)) else $error("spi clock drive");
	sclk_in_a: assert property (spi0_serial_clock == sclk_pad_i &&
		port_e_bit4 == sclk_pad_i) else $error("clock pad input");
	gpio_dir_a: assert property (sclk_gpio_rdata |->
		sclk_pad_oe == port_e_bit4_dir) else $error("port e direction");
	enc_gpio_a: assert property (enc_sel_rdata[1:0] == 2'h2 |->
		enc_pad_oe[0] == port_c_dir[0]) else $error("port c direction");
	sel_load_a: assert property (sel_wr |=>
		sclk_gpio_rdata == $past(sclk_gpio_wdata)) else $error("clock pad select");
endmodule // etsm_sva
bind etsm_pin_mux etsm_sva chk_u (.*);
`default_nettype wire

// >>> verification/etsm_pin_mux_tb.sv
`timescale 1ns/1ps
`default_nettype none
module etsm_pin_mux_tb;
	logic sys_clk = 1'h0, sys_rst = 1'h1, sel_wr = 1'h0, pullup_wr = 1'h0, sclk_gpio_wdata = 1'h0;
	logic [7:0] enc_sel_wdata = 8'h00, port_c_pullup_enable_reg = 8'hff, enc_sel_rdata, es;
	logic [7:0] port_e_pullup_enable_reg = 8'hff, system_pullup_disable_reg = 8'h00;
	logic [3:0] enc_pad_i, enc_pad_o, enc_pad_oe, enc_pad_pu_en, timer_a_i, port_c_i, eo, ev;
	logic [3:0] timer_a_o = 4'h0, timer_a_oe = 4'h0, port_c_o = 4'h0, port_c_dir = 4'h0;
	logic spi0_master = 1'h0, spi0_clk_o = 1'h0, port_e_bit4_o = 1'h0, port_e_bit4_dir = 1'h0;
	logic spi0_serial_clock, sclk_pad_i, sclk_pad_o, sclk_pad_oe, sclk_pad_pu_en, port_e_bit4;
	logic sclk_gpio_rdata, test_rst_pad_n = 1'h0, tap_rst, test_rst_pu_en, soe;
	logic enc0_phase_a, enc0_phase_b, enc0_index_in, enc0_home_in;
	logic [4:0] ext_en = 5'h00, ext_v = 5'h00;
	wire  [4:0] lvl;
	int bad_count = 0, check_count = 0, cyc = 0, sel_m[4], sclk_m, pur_c, pur_e, pudr_m;
	etsm_pin_mux dut_u (.*);
	etsm_board brd_u (.sys_clk, .dev_oe({sclk_pad_oe, enc_pad_oe}), .dev_o({sclk_pad_o, enc_pad_o}),
		.pu_en({sclk_pad_pu_en, enc_pad_pu_en}), .ext_en, .ext_v, .lvl);
	assign {sclk_pad_i, enc_pad_i} = lvl;
	initial forever #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 2000) begin
			bad_count++;
			end_of_test();
		end
	end
	task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic end_of_test();
		if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		void'($urandom(67458));
		// Test reset held low with device reset for a full restart
		repeat (20) @(posedge sys_clk);
		for (int n = 0; n < 400; n++) begin
			#1;
			// One-cycle device reset in mid-run, test reset kept high
			sys_rst = n == 200;
			{sel_wr, pullup_wr, sclk_gpio_wdata, spi0_master, spi0_clk_o} = 5'($urandom);
			{port_e_bit4_o, port_e_bit4_dir, ext_en, ext_v} = 12'($urandom);
			{enc_sel_wdata, port_c_pullup_enable_reg, port_e_pullup_enable_reg,
				system_pullup_disable_reg} = $urandom;
			{timer_a_o, timer_a_oe, port_c_o, port_c_dir} = 16'($urandom);
			test_rst_pad_n = n == 200 ? 1'h1 : 1'($urandom);
			@(posedge sys_clk);
			#1;
			if (sys_rst || n == 0) begin
				sel_m = '{0, 0, 0, 0};
				{sclk_m, pur_c, pur_e, pudr_m} = {32'h0, 32'hff, 32'hff, 32'h0};
			end
			if (!sys_rst && sel_wr) begin
				for (int g = 0; g < 4; g++) sel_m[g] = enc_sel_wdata[2*g+:2] % 3;
				sclk_m = sclk_gpio_wdata;
			end
			if (!sys_rst && pullup_wr) begin
				{pur_c, pur_e} = {24'h0, port_c_pullup_enable_reg, 24'h0, port_e_pullup_enable_reg};
				pudr_m = system_pullup_disable_reg;
			end
			for (int g = 0; g < 4; g++) begin
				eo[g] = sel_m[g] == 1 ? timer_a_oe[g] : sel_m[g] == 2 ? port_c_dir[g] : 1'h0;
				ev[g] = sel_m[g] == 1 ? timer_a_o[g] : port_c_o[g];
				es[2*g+:2] = 2'(sel_m[g]);
			end
			soe = sclk_m ? port_e_bit4_dir : spi0_master;
			chk("enc_sel", es, enc_sel_rdata);
			chk("enc_oe", 8'(eo), 8'(enc_pad_oe));
			chk("enc_o", 8'(ev & eo), 8'(enc_pad_o & eo));
			chk("enc_pu", 8'(pur_c[7:4]), 8'(enc_pad_pu_en));
			chk("enc_in", {enc_pad_i, enc_pad_i}, {timer_a_i, port_c_i});
			chk("dec_in", 8'(enc_pad_i), {4'h0, enc0_home_in, enc0_index_in, enc0_phase_b,
				enc0_phase_a});
			chk("sclk", {2'h0, soe, soe & (sclk_m ? port_e_bit4_o : spi0_clk_o), sclk_pad_i,
				sclk_pad_i, pur_e[4], sclk_m[0]}, {2'h0, sclk_pad_oe, sclk_pad_oe & sclk_pad_o,
				spi0_serial_clock, port_e_bit4, sclk_pad_pu_en, sclk_gpio_rdata});
			chk("test", {6'h0, !test_rst_pad_n, !pudr_m[0]}, {6'h0, tap_rst, test_rst_pu_en});
		end
		end_of_test();
	end
endmodule // etsm_pin_mux_tb
`default_nettype wire
